// [rtl/cgw_consts.svh]
/*
 * constants of the colour gain / readout window pixel path: register
 * offsets, field positions, reset values and arithmetic scales.
 * assumes it is included by bare name from the design files.
 */
// Behaviour
// [RULE1] sensor has line a (red/green), line b (green/blue)
// [RULE2] second-line green gain disabled after power-up
// [RULE3] enabled: line a green gets global plus green
// [RULE4] enabled: line b green gets global plus green2
// [RULE5] disabled: all green get global plus green
// [RULE6] enabling loads green2 from green; writes replace it
// [RULE7] green2 returns to default on every power-up
// [RULE8] global gain ceiling lowered by colour extra gains
// [RULE9] colour gain set as dB or raw integer
// [RULE10] only window pixels are transmitted, others dropped
// [RULE11] window is start through start plus length minus one
// [RULE12] one window serves both sensor lines
// [RULE13] software starts window at pixel one or above
// [RULE14] three colour mode start steps 16 or 32
// [RULE15] unprocessed modes start steps 32 or 64
// [RULE16] small sensors: length at least 256, step 32
// [RULE17] large sensor: length at least 2048, step 64; the code takes step 64 in unprocessed mode only, step 32 in the other modes
// [RULE18] start plus length at most line pixels plus one
// [RULE19] standard shading factor at most 1.5
// [RULE20] extended shading factor at most 4.0
// [RULE21] extended shading has coarser coefficient steps
// [RULE22] shading files only loaded into matching variant
// [RULE23] gain setting over 4096 scales pixel values
// [RULE24] software keeps each colour total at most 12 dB
// [RULE25] window pixels leave in ascending order from start
// [RULE26] bad window writes rejected, old window kept
`ifndef CGW_CONSTS_SVH
`define CGW_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (absolute dB alias sits at raw offset plus 0x40)
// ----------------------------------------------------------------
`define CGW_OFF_GAIN 8'h00
`define CGW_OFF_RED 8'h04
`define CGW_OFF_GREEN 8'h08
`define CGW_OFF_BLUE 8'h0C
`define CGW_OFF_GREEN2 8'h10
`define CGW_OFF_G2EN 8'h14
`define CGW_OFF_WSTART 8'h18
`define CGW_OFF_WLEN 8'h1C
`define CGW_OFF_MODE 8'h20
`define CGW_OFF_STATUS 8'h24
`define CGW_ABS_BIT 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CGW_GAIN_RST 14'h1000
`define CGW_RED_RST 14'h1000
`define CGW_GREEN_RST 14'h1800
`define CGW_BLUE_RST 14'h2000
`define CGW_WSTART_RST 14'h0001
`define CGW_WLEN_RST 14'h0800

// ----------------------------------------------------------------
// arithmetic and limits
// ----------------------------------------------------------------
`define CGW_GAIN_SHIFT 12
`define CGW_GAIN_MIN 14'h0AAB
`define CGW_GAIN_MAX 14'h3FFF
`define CGW_DB_MIN 5'h1D
`define CGW_DB_MAX 5'h0C
`define CGW_SHADE_SHIFT 10
`define CGW_SHADE_ONE 13'h0400
`define CGW_PIX_MAX 12'hFFF
`define CGW_LINE_BASE 15'h0800
`define CGW_LEN_MIN_SMALL 14'h0100
`define CGW_LEN_MIN_LARGE 14'h0800

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CGW_STAT_REJ_BIT 0
`define CGW_STAT_G2_BIT 1

`endif

// [rtl/cgw_pixel_path.sv]
/*
 * colour gain, readout window and shading correction for one pixel
 * stream, with its control registers on a plain strobe port.
 * assumes the pixel source runs on clock_in, marks the first pixel of
 * each sensor line with sol, and never stalls; no back-pressure exists.
 */
`timescale 1ns/10ps
`include "cgw_consts.svh"

module cgw_pixel_path (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire cgw_pkg::cgw_pix_in_t pix_in,
	output cgw_pkg::cgw_pix_out_t pix_out
);

	// ------------------------------------------------------------
	// dB to raw setting, whole dB from -3 to +12
	// ------------------------------------------------------------
	function automatic logic [13:0] db_to_raw(input logic [4:0] db);
		logic [13:0] r;
		r = 14'h1000;
		case (db)
			5'h1D: r = 14'h0B54;
			5'h1E: r = 14'h0CB6;
			5'h1F: r = 14'h0E43;
			5'h00: r = 14'h1000;
			5'h01: r = 14'h11F4;
			5'h02: r = 14'h1425;
			5'h03: r = 14'h169A;
			5'h04: r = 14'h195C;
			5'h05: r = 14'h1C74;
			5'h06: r = 14'h1FED;
			5'h07: r = 14'h23D2;
			5'h08: r = 14'h2831;
			5'h09: r = 14'h2D18;
			5'h0A: r = 14'h3299;
			5'h0B: r = 14'h38C5;
			5'h0C: r = 14'h3FB2;
			default: r = 14'h1000;
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [13:0] gain_reg, red_reg, green_reg, blue_reg, green2_reg;
	logic g2en_reg;
	logic [13:0] wstart_reg, wlen_reg;
	cgw_pkg::cgw_mode_t mode_reg;
	logic rej_reg;
	logic [31:0] rdata_reg;

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	wire logic is_abs = addr_in[`CGW_ABS_BIT];
	wire logic [7:0] base_addr = {1'b0, addr_in[6:0]} &
		~(8'h01 << `CGW_ABS_BIT);
	wire logic wr_gain = wr_in && base_addr == `CGW_OFF_GAIN;
	wire logic wr_red = wr_in && base_addr == `CGW_OFF_RED;
	wire logic wr_green = wr_in && base_addr == `CGW_OFF_GREEN;
	wire logic wr_blue = wr_in && base_addr == `CGW_OFF_BLUE;
	wire logic wr_green2 = wr_in && base_addr == `CGW_OFF_GREEN2;
	wire logic wr_g2en = wr_in && !is_abs &&
		addr_in == `CGW_OFF_G2EN;
	wire logic wr_wstart = wr_in && !is_abs &&
		addr_in == `CGW_OFF_WSTART;
	wire logic wr_wlen = wr_in && !is_abs && addr_in == `CGW_OFF_WLEN;
	wire logic wr_mode = wr_in && !is_abs && addr_in == `CGW_OFF_MODE;
	wire logic wr_status = wr_in && !is_abs &&
		addr_in == `CGW_OFF_STATUS;

	// ------------------------------------------------------------
	// gain value from either field
	// ------------------------------------------------------------
	wire logic [4:0] wr_db = wdata_in[4:0];
	wire logic db_ok = $signed(wr_db) >= $signed(`CGW_DB_MIN) &&
		$signed(wr_db) <= $signed(`CGW_DB_MAX);
	wire logic [13:0] wr_raw = wdata_in[13:0];
	wire logic raw_ok = wdata_in[31:14] == 18'h00000 &&
		wr_raw >= `CGW_GAIN_MIN && wr_raw <= `CGW_GAIN_MAX;
	wire logic [13:0] wr_gval = is_abs ? db_to_raw(wr_db) : wr_raw; // [RULE9]
	wire logic gval_ok = is_abs ? db_ok : raw_ok; // [RULE9]

	// ------------------------------------------------------------
	// global gain ceiling against each colour's total
	// ------------------------------------------------------------
	// products compare in the raw domain: adding dB is multiplying
	wire logic [27:0] tot_red = wr_gval * red_reg;
	wire logic [27:0] tot_green = wr_gval * green_reg;
	wire logic [27:0] tot_blue = wr_gval * blue_reg;
	wire logic [27:0] tot_green2 = wr_gval * green2_reg;
	wire logic [27:0] tot_cap = {`CGW_GAIN_MAX, 14'h0000} >> 2;
	wire logic [27:0] tot_lim = tot_cap | 28'h0000FFF;
	wire logic gain_fits = tot_red <= tot_lim && tot_green <= tot_lim &&
		tot_blue <= tot_lim && (!g2en_reg || tot_green2 <= tot_lim); // [RULE8]
	wire logic gain_take = wr_gain && gval_ok && gain_fits; // [RULE8]

	// ------------------------------------------------------------
	// readout window checks
	// ------------------------------------------------------------
	wire logic big_sensor = mode_reg.size == cgw_pkg::CGW_SZ_8K;
	wire logic [14:0] line_pix = `CGW_LINE_BASE << mode_reg.size;
	wire logic three_col =
		mode_reg.line_mode == cgw_pkg::CGW_LM_THREE_COLOUR;
	wire logic [5:0] start_mask = three_col ?
		(big_sensor ? 6'h1F : 6'h0F) : (big_sensor ? 6'h3F : 6'h1F);
	wire logic [5:0] len_mask = big_sensor &&
		mode_reg.line_mode == cgw_pkg::CGW_LM_UNPROCESSED ?
		6'h3F : 6'h1F;
	wire logic [13:0] len_min = big_sensor ?
		`CGW_LEN_MIN_LARGE : `CGW_LEN_MIN_SMALL;

	function automatic logic win_ok(input logic [13:0] st,
		input logic [13:0] ln, input logic [5:0] smask,
		input logic [5:0] lmask, input logic [13:0] lmin,
		input logic [14:0] npix);
		logic [13:0] st_m1;
		logic [14:0] sum;
		st_m1 = st - 14'h0001;
		sum = {1'b0, st} + {1'b0, ln};
		return st != 14'h0000 && (st_m1[5:0] & smask) == 6'h00 &&
			ln >= lmin && (ln[5:0] & lmask) == 6'h00 &&
			sum <= npix + 15'h0001;
	endfunction

	wire logic [13:0] new_start = wr_wstart ? wdata_in[13:0] : wstart_reg;
	wire logic [13:0] new_len = wr_wlen ? wdata_in[13:0] : wlen_reg;
	wire logic win_fit = wdata_in[31:14] == 18'h00000 &&
		win_ok(new_start, new_len, start_mask, len_mask, len_min,
		line_pix); // [RULE26]
	wire logic win_take = (wr_wstart || wr_wlen) && win_fit; // [RULE26]
	wire logic rej_set = ((wr_wstart || wr_wlen) && !win_fit) ||
		(wr_in && is_abs && !gval_ok) || (wr_gain && !gain_take);

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			gain_reg <= `CGW_GAIN_RST;
			red_reg <= `CGW_RED_RST;
			green_reg <= `CGW_GREEN_RST;
			blue_reg <= `CGW_BLUE_RST;
			green2_reg <= `CGW_GREEN_RST; // [RULE7]
			g2en_reg <= 1'b0; // [RULE2]
			wstart_reg <= `CGW_WSTART_RST;
			wlen_reg <= `CGW_WLEN_RST;
			mode_reg <= '0;
		end else begin
			if (gain_take)
				gain_reg <= wr_gval;
			if (wr_red && gval_ok)
				red_reg <= wr_gval;
			if (wr_green && gval_ok)
				green_reg <= wr_gval;
			if (wr_blue && gval_ok)
				blue_reg <= wr_gval;
			if (wr_g2en && wdata_in[0] && !g2en_reg)
				green2_reg <= green_reg; // [RULE6]
			else if (wr_green2 && gval_ok && g2en_reg)
				green2_reg <= wr_gval; // [RULE6]
			if (wr_g2en)
				g2en_reg <= wdata_in[0];
			if (win_take) begin
				wstart_reg <= new_start; // [RULE11]
				wlen_reg <= new_len; // [RULE11]
			end
			if (wr_mode)
				mode_reg <= wdata_in[4:0];
		end
	end

	// a refused write and a clear in one cycle leave the flag set
	always_ff @(posedge clock_in) begin
		if (rst_in)
			rej_reg <= 1'b0;
		else if (rej_set)
			rej_reg <= 1'b1;
		else if (wr_status && wdata_in[`CGW_STAT_REJ_BIT])
			rej_reg <= 1'b0;
	end

	// ------------------------------------------------------------
	// read back
	// ------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		case (base_addr)
			`CGW_OFF_GAIN: rd_mux = {18'h00000, gain_reg};
			`CGW_OFF_RED: rd_mux = {18'h00000, red_reg};
			`CGW_OFF_GREEN: rd_mux = {18'h00000, green_reg};
			`CGW_OFF_BLUE: rd_mux = {18'h00000, blue_reg};
			`CGW_OFF_GREEN2: rd_mux = {18'h00000, green2_reg};
			`CGW_OFF_G2EN: rd_mux = {31'h00000000, g2en_reg};
			`CGW_OFF_WSTART: rd_mux = {18'h00000, wstart_reg};
			`CGW_OFF_WLEN: rd_mux = {18'h00000, wlen_reg};
			`CGW_OFF_MODE: rd_mux = {27'h0000000, mode_reg};
			`CGW_OFF_STATUS: rd_mux = {30'h00000000, g2en_reg, rej_reg};
			default: rd_mux = 32'h00000000;
		endcase
		if (is_abs && base_addr > `CGW_OFF_GREEN2)
			rd_mux = 32'h00000000;
	end

	always_ff @(posedge clock_in) begin
		if (rst_in)
			rdata_reg <= 32'h00000000;
		else
			rdata_reg <= rd_in ? rd_mux : 32'h00000000;
	end
	assign rdata_out = rdata_reg;

	// ------------------------------------------------------------
	// pixel position and window
	// ------------------------------------------------------------
	// the counter runs from the line start so both lines index alike
	logic [13:0] idx_reg;
	wire logic [13:0] cur_idx = pix_in.sol ? 14'h0001 :
		idx_reg + 14'h0001; // [RULE25]
	wire logic [14:0] win_end = {1'b0, wstart_reg} +
		{1'b0, wlen_reg} - 15'h0001;
	wire logic in_win = cur_idx >= wstart_reg &&
		{1'b0, cur_idx} <= win_end; // [RULE11] [RULE12]
	wire logic first_in_win = cur_idx == wstart_reg;

	always_ff @(posedge clock_in) begin
		if (rst_in)
			idx_reg <= 14'h0000;
		else if (pix_in.valid)
			idx_reg <= cur_idx;
	end

	// ------------------------------------------------------------
	// colour gain selection
	// ------------------------------------------------------------
	wire logic green_b2 = g2en_reg && pix_in.line_b; // [RULE1] [RULE4]
	wire logic [13:0] green_sel = green_b2 ?
		green2_reg : green_reg; // [RULE3] [RULE5]
	wire logic [13:0] col_gain =
		pix_in.colour == cgw_pkg::CGW_COL_RED ? red_reg :
		pix_in.colour == cgw_pkg::CGW_COL_GREEN ? green_sel :
		pix_in.colour == cgw_pkg::CGW_COL_BLUE ? blue_reg :
		`CGW_RED_RST;

	// ------------------------------------------------------------
	// stage one: global gain, keep colour gain and shade factor
	// ------------------------------------------------------------
	wire logic [25:0] g_prod = pix_in.data * gain_reg; // [RULE23]
	// standard: 1 + floor(c/2)/1024, max 1.4990; extended: 1 + 3c/1024, max 3.997
	wire logic [12:0] shade_std = `CGW_SHADE_ONE +
		{4'h0, pix_in.shade[9:1]}; // [RULE19]
	// widened before the product so 3 x 1023 keeps its top bits
	wire logic [12:0] shade_ext = `CGW_SHADE_ONE +
		({3'h0, pix_in.shade} * 13'h0003); // [RULE20] [RULE21]
	wire logic [12:0] shade_f = mode_reg.extended_range_shading ?
		shade_ext : shade_std;

	cgw_pkg::cgw_pix_out_t s1_reg;
	logic [13:0] s1_val_reg, s1_gain_reg;
	logic [12:0] s1_shade_reg;

	always_ff @(posedge clock_in) begin
		if (rst_in)
			s1_reg <= '0;
		else begin
			s1_reg.valid <= pix_in.valid && in_win; // [RULE10]
			s1_reg.sol <= pix_in.valid && first_in_win;
			s1_reg.line_b <= pix_in.line_b;
			s1_reg.colour <= pix_in.colour;
			s1_reg.data <= 12'h000;
		end
	end

	always_ff @(posedge clock_in) begin
		s1_val_reg <= g_prod[25:`CGW_GAIN_SHIFT];
		s1_gain_reg <= col_gain;
		s1_shade_reg <= shade_f;
	end

	// ------------------------------------------------------------
	// stage two: colour gain, shading, saturation
	// ------------------------------------------------------------
	wire logic [27:0] c_prod = s1_val_reg * s1_gain_reg; // [RULE23]
	wire logic [15:0] c_val = c_prod[27:`CGW_GAIN_SHIFT];
	wire logic [28:0] s_prod = c_val * s1_shade_reg;
	wire logic [18:0] s_val = s_prod[28:`CGW_SHADE_SHIFT];
	// global, colour and extended shading factors each reach about 4x, so this clamp takes both gain and shading excess
	wire logic [11:0] sat_val = s_val > 19'({`CGW_PIX_MAX}) ?
		`CGW_PIX_MAX : s_val[11:0];

	always_ff @(posedge clock_in) begin
		if (rst_in)
			pix_out <= '0;
		else begin
			pix_out.valid <= s1_reg.valid; // [RULE10] [RULE25]
			pix_out.sol <= s1_reg.sol;
			pix_out.line_b <= s1_reg.line_b;
			pix_out.colour <= s1_reg.colour;
			pix_out.data <= s1_reg.valid ? sat_val : 12'h000;
		end
	end

endmodule

// [rtl/cgw_pkg.sv]
/*
 * types of the colour gain / readout window pixel path.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package cgw_pkg;

	typedef enum logic [1:0] {
		CGW_LM_THREE_COLOUR,
		CGW_LM_UNPROCESSED,
		CGW_LM_ENHANCED_UNPROCESSED,
		CGW_LM_SINGLE
	} cgw_line_mode_t;

	typedef enum logic [1:0] {
		CGW_SZ_2K,
		CGW_SZ_4K,
		CGW_SZ_8K,
		CGW_SZ_RSVD
	} cgw_size_t;

	typedef enum logic [1:0] {
		CGW_COL_RED,
		CGW_COL_GREEN,
		CGW_COL_BLUE,
		CGW_COL_NONE
	} cgw_colour_t;

	// mode register layout, bit 4 down to bit 0
	typedef struct packed {
		logic extended_range_shading;
		cgw_size_t size;
		cgw_line_mode_t line_mode;
	} cgw_mode_t;

	typedef struct packed {
		logic valid;
		logic sol;
		logic line_b;
		cgw_colour_t colour;
		logic [11:0] data;
		logic [9:0] shade;
	} cgw_pix_in_t;

	typedef struct packed {
		logic valid;
		logic sol;
		logic line_b;
		cgw_colour_t colour;
		logic [11:0] data;
	} cgw_pix_out_t;

endpackage

// [tb/cgw_grabber.sv]
/*
 * frame grabber model: takes every transmitted pixel and counts lines.
 * assumes pixels arrive on clock_in; it never back-pressures, as the
 * link has no stall path.
 */
`timescale 1ns/10ps
module cgw_grabber (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire cgw_pkg::cgw_pix_out_t pix_in,
	output logic got_out,
	output cgw_pkg::cgw_pix_out_t pix_held_out,
	output logic [15:0] line_cnt_out
);
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			got_out <= 1'b0;
			pix_held_out <= '0;
			line_cnt_out <= 16'h0000;
		end else begin
			got_out <= pix_in.valid;
			if (pix_in.valid) pix_held_out <= pix_in;
			if (pix_in.valid && pix_in.sol) line_cnt_out <= line_cnt_out + 16'h0001;
		end
	end
endmodule

// [tb/cgw_pixel_path_chk.sv]
/*
 * port checker for the colour gain / readout window pixel path.
 * assumes it is bound to the pixel path top and sees only its ports.
 */
`timescale 1ns/10ps
module cgw_pixel_path_chk (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire cgw_pkg::cgw_pix_in_t pix_in,
	input wire cgw_pkg::cgw_pix_out_t pix_out
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	property p_rd_idle; !rd_in |=> rdata_out == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data seen without a read");
	property p_unmapped; rd_in && addr_in == 8'h30 |=> rdata_out == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_rst; $fell(rst_in) |-> pix_out == '0 && rdata_out == 32'h0;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not cleared by reset");
	property p_g2_stat; wr_in && addr_in == 8'h14 && wdata_in[0]
		##[1:2] (rd_in && addr_in == 8'h24) |=> rdata_out[1] == 1'b1;
	endproperty
	a_g2_stat: assert property (p_g2_stat)
		else $error("second green enable not shown in status");
	property p_cause; pix_out.valid |-> $past(pix_in.valid, 2); endproperty
	a_cause: assert property (p_cause)
		else $error("pixel out without pixel in two cycles before");
	property p_no_in; !pix_in.valid |-> ##2 !pix_out.valid; endproperty
	a_no_in: assert property (p_no_in)
		else $error("pixel out from an idle cycle");
	property p_colour;
		pix_out.valid |-> pix_out.colour == $past(pix_in.colour, 2);
	endproperty
	a_colour: assert property (p_colour)
		else $error("colour changed on the way");
	property p_line;
		pix_out.valid |-> pix_out.line_b == $past(pix_in.line_b, 2);
	endproperty
	a_line: assert property (p_line)
		else $error("sensor line changed on the way");
	property p_idle_data; !pix_out.valid |-> pix_out.data == 12'h000;
	endproperty
	a_idle_data: assert property (p_idle_data)
		else $error("dropped pixel leaks data");
	property p_sol; pix_out.sol |-> pix_out.valid; endproperty
	a_sol: assert property (p_sol)
		else $error("line start on an idle cycle");
endmodule

bind cgw_pixel_path cgw_pixel_path_chk i_chk (.clock_in(clock_in),
	.rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
	.rd_in(rd_in), .rdata_out(rdata_out), .pix_in(pix_in), .pix_out(pix_out));

// [tb/tb.sv]
/*
 * self-checking bench of the pixel path: registers, window, gains.
 * assumes the design package, the grabber model and the bound checker.
 */
`timescale 1ns/10ps
module tb;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [31:0] rdata_out;
	cgw_pkg::cgw_pix_in_t pix_in = '0;
	cgw_pkg::cgw_pix_out_t pix_out, held;
	logic got, rd_was = 1'b0, g2en = 1'b0, ext = 1'b0;
	logic [15:0] lines;
	int mismatches = 0, n_tests = 0, exp_lines = 0;
	logic [31:0] rq[$];
	cgw_pkg::cgw_pix_out_t pq[$];
	logic [13:0] gain = 14'h1000, red = 14'h1000, grn = 14'h1800;
	logic [13:0] blu = 14'h2000, g2 = 14'h1800, ws = 14'h0001, wl = 14'h0800;
	// the last three offsets are unmapped and must read back as zero
	logic [31:0] rst_vals [13] = '{32'h1000, 32'h1000, 32'h1800, 32'h2000,
		32'h1800, 32'h0, 32'h1, 32'h800, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	// address, value, accepted; software keeps to the steps except here
	// a full-line length allows start 1 only, so shorten it first
	logic [22:0] rows [21] = '{{8'h1C, 14'h100, 1'b1},
		{8'h18, 14'h022, 1'b0}, {8'h18, 14'h000, 1'b0},
		{8'h18, 14'h011, 1'b1}, {8'h20, 14'h001, 1'b1}, {8'h18, 14'h031, 1'b0},
		{8'h18, 14'h041, 1'b1}, {8'h20, 14'h002, 1'b1}, {8'h1C, 14'h0FF, 1'b0},
		{8'h1C, 14'h120, 1'b1}, {8'h1C, 14'h12C, 1'b0}, {8'h18, 14'h701, 1'b0},
		{8'h1C, 14'h100, 1'b1}, {8'h18, 14'h701, 1'b1}, {8'h20, 14'h003, 1'b1},
		{8'h20, 14'h009, 1'b1}, {8'h1C, 14'h820, 1'b0}, {8'h1C, 14'h840, 1'b1},
		{8'h20, 14'h000, 1'b1}, {8'h1C, 14'h100, 1'b1}, {8'h18, 14'h021, 1'b1}};

	always #2.5 clock_in = ~clock_in;

	cgw_pixel_path i_dut (.clock_in(clock_in), .rst_in(rst_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .pix_in(pix_in), .pix_out(pix_out));
	cgw_grabber i_grab (.clock_in(clock_in), .rst_in(rst_in), .pix_in(pix_out),
		.got_out(got), .pix_held_out(held), .line_cnt_out(lines));

	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
	endtask
	// expected pixel from the gain chain and shading factor
	function automatic logic [11:0] model(input cgw_pkg::cgw_pix_in_t p);
		longint v;
		logic [13:0] cg;
		cg = (p.colour == cgw_pkg::CGW_COL_RED) ? red :
			(p.colour == cgw_pkg::CGW_COL_BLUE) ? blu :
			(p.colour == cgw_pkg::CGW_COL_GREEN) ? ((g2en && p.line_b) ? g2 : grn)
			: 14'h1000;
		v = ((longint'(p.data) * gain) >> 12) * cg >> 12;
		v = ext ? (v * (1024 + 3 * p.shade)) >> 10 : (v * (1024 + (p.shade >> 1))) >> 10;
		return (v > 4095) ? 12'hFFF : v[11:0];
	endfunction
	task send(input logic lb, input int n);
		cgw_pkg::cgw_pix_in_t p;
		for (int i = 1; i <= n; i++) begin
			p = '{1'b1, i == 1, lb, cgw_pkg::cgw_colour_t'(2'(lb + $urandom_range(1))),
				12'($urandom), 10'($urandom)};
			if (i >= ws && i < ws + wl) pq.push_back('{1'b1, i == ws, lb, p.colour, model(p)});
			@(posedge clock_in);
			pix_in <= p;
		end
		@(posedge clock_in);
		pix_in <= '0;
		exp_lines++;
	endtask

	always @(negedge clock_in) begin
		if (rd_was) check("rdata", rdata_out, rq.pop_front());
		rd_was = rd_in;
		if (got) check("pixel", 32'(held), 32'(pq.pop_front()));
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] a;
		logic [13:0] d;
		logic ok;
		void'($urandom(49));
		repeat (2) @(posedge clock_in);
		rst_in <= 1'b0;
		foreach (rst_vals[k]) rd(8'(k * 4), rst_vals[k]);
		send(1'b0, 40);
		send(1'b1, 40);
		foreach (rows[k]) begin
			{a, d, ok} = rows[k];
			wr(a, {18'h0, d});
			if (ok && a == 8'h18) ws = d;
			if (ok && a == 8'h1C) wl = d;
			rd(a, (a == 8'h18) ? ws : (a == 8'h1C) ? wl : d);
			rd(8'h24, {31'h0, !ok});
			wr(8'h24, 32'h1);
		end
		send(1'b0, 300);
		send(1'b1, 300);
		wr(8'h48, 32'h6);
		grn = 14'h1FED;
		rd(8'h08, 32'h1FED);
		wr(8'h04, 32'h2000);
		red = 14'h2000;
		wr(8'h14, 32'h1);
		g2en = 1'b1;
		rd(8'h24, 32'h2);
		rd(8'h10, 32'h1FED);
		wr(8'h10, 32'h1000);
		g2 = 14'h1000;
		send(1'b0, 300);
		send(1'b1, 300);
		wr(8'h08, 32'h1400);
		grn = 14'h1400;
		rd(8'h10, 32'h1000);
		wr(8'h14, 32'h0);
		g2en = 1'b0;
		send(1'b1, 300);
		wr(8'h00, 32'h3FFF);
		rd(8'h00, 32'h1000);
		rd(8'h24, 32'h1);
		wr(8'h24, 32'h1);
		wr(8'h00, 32'h0AAA);
		rd(8'h00, 32'h1000);
		wr(8'h00, 32'h1800);
		gain = 14'h1800;
		rd(8'h00, 32'h1800);
		wr(8'h20, 32'h10);
		ext = 1'b1;
		// shade words now stand for a file made by the extended variant
		send(1'b0, 300);
		send(1'b1, 300);
		repeat (4) @(posedge clock_in);
		check("lines", 32'(lines), 32'(exp_lines));
		check("left", 32'(pq.size()), 32'h0);
		stop_test();
	end

	initial begin
		#250000;
		mismatches++;
		stop_test();
	end
endmodule
